// ===== hdl/psc_pkg.sv
// Package with the address map, field layouts and bus carrier of the peripheral register bank.
package psc_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 32;
    localparam int DATA_W     = 32;
    localparam int STRB_W     = 4;
    localparam int NUM_PERIPH = 4;

    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    // The whole peripheral region is the top 3 Mbyte of the address space.
    localparam logic [31:0] REGION_BASE     = 32'hffd0_0000;
    localparam logic [31:0] PERIPH_WIN_SIZE = 32'h0000_4000;
    localparam logic [31:0] INTC_WIN_SIZE   = 32'h0000_1000;
    localparam logic [31:0] PERIPH_BASE0    = 32'hfffe_0000;
    localparam logic [31:0] INTC_BASE       = 32'hffff_f000;

    // ------------------------------------------------------------------
    // Register offsets inside a window
    // ------------------------------------------------------------------
    localparam logic [13:0] OFS_SET = 14'h0000;
    localparam logic [13:0] OFS_CLR = 14'h0004;
    localparam logic [13:0] OFS_VAL = 14'h0008;
    localparam logic [13:0] INTC_OFS_MASK = 14'h0fff;

    localparam logic [31:0] VAL_RESET = 32'h0000_0000;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        PSC_PH_IDLE   = 1'b0,
        PSC_PH_ACCESS = 1'b1
    } psc_phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] strb;
        logic              write;
    } psc_req_t;

endpackage

// ===== hdl/psc_regs.sv
// Peripheral bus slave with per-window set, clear and value register aliases.
`timescale 1ns/1ps
module psc_regs (
    input  wire logic                                         sys_clk,
    input  wire logic                                         rstn,
    input  wire logic                                         psel,
    input  wire logic                                         penable,
    input  wire logic                                         pwrite,
    input  wire logic [psc_pkg::ADDR_W-1:0]                   paddr,
    input  wire logic [psc_pkg::DATA_W-1:0]                   pwdata,
    input  wire logic [psc_pkg::STRB_W-1:0]                   pstrb,
    output logic      [psc_pkg::DATA_W-1:0]                   prdata,
    output logic                                              pready,
    output logic                                              pslverr,
    output logic      [psc_pkg::NUM_PERIPH-1:0][psc_pkg::DATA_W-1:0] periph_val,
    output logic      [psc_pkg::DATA_W-1:0]                   intc_val
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic win_hit(input logic [31:0] addr,
                                     input logic [31:0] base,
                                     input logic [31:0] size);
        logic [31:0] mask;
        mask = ~(size - 32'h0000_0001);
        return ((addr & mask) == base);
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    psc_pkg::psc_req_t                  req;
    psc_pkg::psc_phase_t                phase_reg;
    logic [psc_pkg::NUM_PERIPH-1:0]     hit_p;
    logic                               hit_i;
    logic                               in_region;
    logic [13:0]                        off_p;
    logic [13:0]                        off_i;
    logic [31:0]                        wmask;
    logic [31:0]                        rd_next;
    logic                               setup;
    logic                               commit;
    logic [psc_pkg::DATA_W-1:0]         prdata_reg;
    logic                               pready_reg;
    logic [psc_pkg::NUM_PERIPH-1:0][psc_pkg::DATA_W-1:0] periph_val_reg;
    logic [psc_pkg::DATA_W-1:0]         intc_val_reg;

    assign req     = '{addr: paddr, wdata: pwdata, strb: pstrb, write: pwrite};
    assign setup   = psel && !penable;
    assign commit  = psel && penable && req.write && (phase_reg == psc_pkg::PSC_PH_ACCESS);
    assign wmask   = req.wdata & lane_mask(req.strb);
    assign off_p   = req.addr[13:0];
    assign off_i   = req.addr[13:0] & psc_pkg::INTC_OFS_MASK;

    always_comb begin
        in_region = (req.addr >= psc_pkg::REGION_BASE);
        hit_i     = in_region && win_hit(req.addr, psc_pkg::INTC_BASE,
                                         psc_pkg::INTC_WIN_SIZE);
        for (int k = 0; k < psc_pkg::NUM_PERIPH; k++) begin
            hit_p[k] = in_region && win_hit(req.addr,
                32'(psc_pkg::PERIPH_BASE0 + 32'(32'(k) * psc_pkg::PERIPH_WIN_SIZE)),
                psc_pkg::PERIPH_WIN_SIZE);
        end
    end

    // Set and clear aliases are write-only and read zero, so a stray read
    // of them never hides a pending bit pattern.
    always_comb begin
        rd_next = psc_pkg::RD_ZERO;
        for (int k = 0; k < psc_pkg::NUM_PERIPH; k++) begin
            if (hit_p[k] && off_p == psc_pkg::OFS_VAL) begin
                rd_next = periph_val_reg[k];
            end
        end
        if (hit_i && off_i == psc_pkg::OFS_VAL) begin
            rd_next = intc_val_reg;
        end
    end

    // ------------------------------------------------------------------
    // Bus phase and answer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= psc_pkg::PSC_PH_IDLE;
        end else begin
            case (phase_reg)
                psc_pkg::PSC_PH_IDLE: begin
                    if (setup) begin
                        phase_reg <= psc_pkg::PSC_PH_ACCESS;
                    end
                end
                psc_pkg::PSC_PH_ACCESS: begin
                    phase_reg <= setup ? psc_pkg::PSC_PH_ACCESS : psc_pkg::PSC_PH_IDLE;
                end
                default: begin
                    phase_reg <= psc_pkg::PSC_PH_IDLE;
                end
            endcase
        end
    end

    // The answer is prepared in the setup cycle so that ready and data
    // leave flip-flops and the access phase still needs no wait state.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready_reg <= 1'b0;
            prdata_reg <= psc_pkg::RD_ZERO;
        end else begin
            pready_reg <= setup;
            if (setup && !req.write) begin
                prdata_reg <= rd_next;
            end else if (setup) begin
                prdata_reg <= psc_pkg::RD_ZERO;
            end
        end
    end

    // ------------------------------------------------------------------
    // Stored registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < psc_pkg::NUM_PERIPH; k++) begin
                periph_val_reg[k] <= psc_pkg::VAL_RESET;
            end
        end else if (commit) begin
            for (int k = 0; k < psc_pkg::NUM_PERIPH; k++) begin
                if (hit_p[k] && off_p == psc_pkg::OFS_SET) begin
                    periph_val_reg[k] <= periph_val_reg[k] | wmask;
                end else if (hit_p[k] && off_p == psc_pkg::OFS_CLR) begin
                    periph_val_reg[k] <= periph_val_reg[k] & ~wmask;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            intc_val_reg <= psc_pkg::VAL_RESET;
        end else if (commit && hit_i) begin
            if (off_i == psc_pkg::OFS_SET) begin
                intc_val_reg <= intc_val_reg | wmask;
            end else if (off_i == psc_pkg::OFS_CLR) begin
                intc_val_reg <= intc_val_reg & ~wmask;
            end
        end
    end

    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = 1'b0;
    assign periph_val = periph_val_reg;
    assign intc_val   = intc_val_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    logic set0;
    logic clr0;
    assign set0 = commit && hit_p[0] && off_p == psc_pkg::OFS_SET;
    assign clr0 = commit && hit_p[0] && off_p == psc_pkg::OFS_CLR;

    bus_ready_a: assert property (setup |=> pready ##1 (!pready || $past(setup)))
        else $error("ready not given one cycle after setup");
    set_bits_a: assert property (set0 |=> (periph_val[0] & $past(wmask)) == $past(wmask))
        else $error("set alias did not set bits");
    clr_bits_a: assert property (clr0 |=> (periph_val[0] & $past(wmask)) == 32'h0000_0000)
        else $error("clear alias did not clear bits");
    keep_bits_a: assert property ((set0 || clr0) |=>
        (periph_val[0] & ~$past(wmask)) == ($past(periph_val[0]) & ~$past(wmask)))
        else $error("zero bits changed");
    read_val_a: assert property ((setup && !pwrite && hit_p[0] && off_p == psc_pkg::OFS_VAL)
        |=> prdata == $past(periph_val[0]) && pready)
        else $error("value alias read wrong");
    unmapped_rd_a: assert property ((setup && !pwrite && hit_p == '0 && !hit_i)
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    unmapped_wr_a: assert property ((commit && hit_p == '0 && !hit_i)
        |=> $stable(periph_val) && $stable(intc_val))
        else $error("unmapped write changed state");
    intc_window_a: assert property (hit_i |-> paddr[31:12] == psc_pkg::INTC_BASE[31:12])
        else $error("interrupt window decode wrong");
    region_a: assert property ((hit_p != '0) |-> paddr >= psc_pkg::REGION_BASE)
        else $error("window outside peripheral region");
    byte_lane_a: assert property ((set0 && pstrb == 4'h1)
        |=> periph_val[0][31:8] == $past(periph_val[0][31:8]))
        else $error("byte lane 0 write touched upper bytes");
    // The interrupt window has its own store, so its aliases are guarded apart.
    intc_set_a: assert property ((commit && hit_i && off_i == psc_pkg::OFS_SET)
        |=> (intc_val & $past(wmask)) == $past(wmask))
        else $error("interrupt set alias did not set bits");
    intc_clr_a: assert property ((commit && hit_i && off_i == psc_pkg::OFS_CLR)
        |=> (intc_val & $past(wmask)) == 32'h0000_0000)
        else $error("interrupt clear alias did not clear bits");

    set_write_c: cover property (set0 ##3 clr0);
    val_read_c: cover property (setup && !pwrite && hit_p[1] && off_p == psc_pkg::OFS_VAL);
    intc_write_c: cover property (commit && hit_i && off_i == psc_pkg::OFS_SET);
    back_to_back_c: cover property (commit ##1 setup);

endmodule

// ===== tb/psc_apb_master.sv
// Bus master model standing in for the processor core behind the bus bridge.
`timescale 1ns/1ps
module psc_apb_master (
    input  wire logic        sys_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    output logic             stalled
);
    // ------------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, stalled} = 4'h0;
        {paddr, pwdata, pstrb} = 68'h0;
    end

    // Setup then access phase, held until ready is sampled high or 16 access cycles pass, which sets stalled.
    // Released address and data lines show inverted values so stale data never looks valid.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input int gap, output logic [31:0] rd);
        int n;
        n = 0;
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) stalled = 1'b1;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ===== tb/psc_regs_tb_top.sv
// Self-checking testbench of the peripheral register bank.
`timescale 1ns/1ps
module psc_regs_tb_top;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr, stalled;
    logic [31:0] paddr, pwdata, prdata, intc_val, rd;
    logic [3:0]  pstrb;
    logic [psc_pkg::NUM_PERIPH-1:0][psc_pkg::DATA_W-1:0] periph_val;
    logic [31:0] exp_val [5];
    int          num_errors;
    int          compares;

    psc_regs psc_regs_i (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_val(periph_val), .intc_val(intc_val));
    psc_apb_master psc_apb_master_i (.sys_clk(sys_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .stalled(stalled));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] base_of(input int k);
        return (k < 4) ? psc_pkg::PERIPH_BASE0 + psc_pkg::PERIPH_WIN_SIZE * 32'(k)
                       : psc_pkg::INTC_BASE;
    endfunction

    task automatic acc(input logic w, input int k, input logic [13:0] o, input logic [31:0] d,
                       input logic [3:0] s);
        psc_apb_master_i.xfer(w, base_of(k) + 32'(o), d, s, k, rd);
    endtask

    // Wait one edge so that a write committed at the last edge has landed.
    task automatic check_all();
        @(posedge sys_clk);
        for (int k = 0; k < 4; k++) check(periph_val[k], exp_val[k]);
        check(intc_val, exp_val[4]);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int k = 0; k < 5; k++) exp_val[k] = psc_pkg::VAL_RESET;
        check_all();
        check({30'h0, pready, pslverr}, 32'h0);
    endtask

    task automatic t_set_clear();
        for (int k = 0; k < 5; k++) begin
            acc(1'b1, k, psc_pkg::OFS_SET, 32'ha5a5_0f0f ^ 32'(k), 4'hf);
            exp_val[k] |= 32'ha5a5_0f0f ^ 32'(k);
            acc(1'b1, k, psc_pkg::OFS_CLR, 32'h8000_0f05, 4'hf);
            exp_val[k] &= ~32'h8000_0f05;
            acc(1'b0, k, psc_pkg::OFS_VAL, 32'h0, 4'h0);
            check(rd, exp_val[k]);
            acc(1'b0, k, psc_pkg::OFS_SET, 32'h0, 4'h0);
            check(rd, psc_pkg::RD_ZERO);
        end
        check_all();
    endtask

    // Only the enabled byte lanes change, lane 0 being the low byte.
    task automatic t_strobe();
        acc(1'b1, 0, psc_pkg::OFS_SET, 32'hffff_ffff, 4'h1);
        exp_val[0] |= 32'h0000_00ff;
        acc(1'b1, 0, psc_pkg::OFS_CLR, 32'hffff_ffff, 4'h4);
        exp_val[0] &= ~32'h00ff_0000;
        acc(1'b0, 0, psc_pkg::OFS_VAL, 32'h0, 4'h0);
        check(rd, exp_val[0]);
    endtask

    // Unused offsets, the gap below the interrupt block and addresses outside the windows must not decode.
    task automatic t_unmapped();
        acc(1'b1, 0, psc_pkg::OFS_VAL, 32'hffff_ffff, 4'hf);
        acc(1'b1, 2, 14'h000c, 32'hffff_ffff, 4'hf);
        acc(1'b0, 2, 14'h000c, 32'h0, 4'h0);
        check(rd, psc_pkg::RD_ZERO);
        acc(1'b0, 3, 14'h3ffc, 32'h0, 4'h0);
        check(rd, psc_pkg::RD_ZERO);
        psc_apb_master_i.xfer(1'b0, 32'hffff_c000, 32'h0, 4'h0, 0, rd);
        check(rd, psc_pkg::RD_ZERO);
        psc_apb_master_i.xfer(1'b1, 32'hffff_c000, 32'hffff_ffff, 4'hf, 0, rd);
        psc_apb_master_i.xfer(1'b1, 32'hfffd_c000, 32'hffff_ffff, 4'hf, 0, rd);
        psc_apb_master_i.xfer(1'b1, 32'h0000_0000, 32'hffff_ffff, 4'hf, 0, rd);
        check_all();
    endtask

    task automatic t_midreset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_reset();
        rstn <= 1'b1;
    endtask

    initial begin
        rstn = 1'b0;
        num_errors = 0;
        compares = 0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_set_clear();
        t_strobe();
        t_unmapped();
        t_midreset();
        t_set_clear();
        check({31'h0, stalled}, 32'h0);
        end_sim();
    end

    // About 50 transfers of at most a dozen cycles each fit well inside this span.
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
endmodule
